// *** rtl/pulse_command_encoder_emulation.sv ***
// Pulse command input counter and quadrature encoder output emulation.
// Command pins pass a two-stage synchroniser into core_clk; motor steps come from the drive core.
// Motor steps are one-cycle strobes, four to one A/B period.
// How it works
// - Forward pair pulses count as forward commands
// - Reverse pair pulses count as reverse commands
// - Differential inputs accepted up to higher rate
// - A/B emit programmed pulses per turn
// - A and B offset by quarter period
// - Phase order parameter chooses leading channel
// - One index pulse each full revolution
// - Differential index copies single-ended index
// - Command pulses only in external position mode
`timescale 1ns/10ps
module pulse_command_encoder_emulation #(
   parameter int POS_W = pulse_enc_pkg::POS_WIDTH,
   parameter int PPT_W = pulse_enc_pkg::PPT_WIDTH
) (
   input  wire logic                             core_clk,        // 200 MHz clock
   input  wire logic                             nrst,            // Sync reset, active low
   input  wire pulse_enc_pkg::control_mode_type  control_mode,    // Operating mode
   input  wire pulse_enc_pkg::cmd_pins_type      cmd_pins,        // Command pulse pins
   input  wire logic [PPT_W-1:0]                 pulses_per_turn_param, // A/B pulses per turn
   input  wire logic                             phase_order_param, // 1: A leads forward
   input  wire logic                             motor_step,      // One encoder step
   input  wire logic                             motor_step_dir,  // 1: forward step
   output pulse_enc_pkg::enc_pins_type           enc_pins,        // Emulated encoder pins
   output logic [POS_W-1:0]                      position_command // Command accumulator
);
   import pulse_enc_pkg::*;

   // Derived sizes and pair positions
   localparam int STEP_W = PPT_W + 2;
   localparam int IDX_W  = $clog2(INDEX_WIDTH_CYC + 1);
   localparam int PAIRS  = 2;
   localparam int FWD    = 1;
   localparam int REV    = 0;

   // Command pair decode and synchronisation
   logic [PAIRS-1:0] pair_level;
   logic [PAIRS-1:0] pair_rise;
   logic             ext_mode;
   logic             fwd_count;
   logic             rev_count;

   // Pair active: positive line high and negative line low
   assign pair_level[FWD] = cmd_pins.fwd_pulse_pos & ~cmd_pins.fwd_pulse_neg;
   assign pair_level[REV] = cmd_pins.rev_pulse_pos & ~cmd_pins.rev_pulse_neg;

   for (genvar g = 0; g < PAIRS; g++) begin : g_pair
      // Stage 0 feeds only the next stage
      logic [SYNC_STAGES-1:0] chain;
      logic                   prev;

      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            chain <= '0;
         end else begin
            chain <= {chain[SYNC_STAGES-2:0], pair_level[g]};
         end
      end

      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            prev <= 1'b0;
         end else begin
            prev <= chain[SYNC_STAGES-1];
         end
      end

      // Rising edge only, so a held level counts once
      assign pair_rise[g] = chain[SYNC_STAGES-1] & ~prev;
   end

   // Only the external position mode listens to the pins
   assign ext_mode  = (control_mode == MODE_EXT_POS);
   // Coincident edges on both pairs cancel
   assign fwd_count = pair_rise[FWD] & ~pair_rise[REV] & ext_mode;
   assign rev_count = pair_rise[REV] & ~pair_rise[FWD] & ext_mode;

   // Position command accumulator, wraps in two's complement
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         position_command <= '0;
      end else if (fwd_count) begin
         position_command <= position_command + POS_W'(1);
      end else if (rev_count) begin
         position_command <= position_command - POS_W'(1);
      end
   end

   // Motor position within the turn, in quarter-period steps
   logic [STEP_W-1:0] steps_per_turn;
   logic [STEP_W-1:0] last_step;
   logic [STEP_W-1:0] step_in_turn;
   logic              step_fwd;
   logic              step_rev;
   logic              wrap_fwd;
   logic              wrap_rev;
   logic              turn_done;

   assign steps_per_turn = {pulses_per_turn_param, 2'b00};
   assign last_step      = steps_per_turn - STEP_W'(1);
   // Step strobes split by direction
   assign step_fwd       = motor_step & motor_step_dir;
   assign step_rev       = motor_step & ~motor_step_dir;

   // At or past the boundary, so a smaller count still wraps
   assign wrap_fwd  = step_fwd & (step_in_turn >= last_step);
   assign wrap_rev  = step_rev & (step_in_turn == '0);
   // Index marks the boundary crossing in either direction
   assign turn_done = wrap_fwd | wrap_rev;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         step_in_turn <= '0;
      end else if (wrap_fwd) begin
         step_in_turn <= '0;
      end else if (wrap_rev) begin
         step_in_turn <= last_step;
      end else if (step_fwd) begin
         step_in_turn <= step_in_turn + STEP_W'(1);
      end else if (step_rev) begin
         step_in_turn <= step_in_turn - STEP_W'(1);
      end
   end

   // Quadrature phase walks a Gray path; one step is one quarter period
   typedef enum logic [1:0] {
      QUAD_00 = 2'h0,
      QUAD_01 = 2'h1,
      QUAD_11 = 2'h3,
      QUAD_10 = 2'h2
   } quad_state_type;

   quad_state_type quad_state;
   quad_state_type quad_ahead;
   quad_state_type quad_behind;

   always_comb begin
      unique case (quad_state)
         QUAD_00: begin
            quad_ahead  = QUAD_01;
            quad_behind = QUAD_10;
         end
         QUAD_01: begin
            quad_ahead  = QUAD_11;
            quad_behind = QUAD_00;
         end
         QUAD_11: begin
            quad_ahead  = QUAD_10;
            quad_behind = QUAD_01;
         end
         QUAD_10: begin
            quad_ahead  = QUAD_00;
            quad_behind = QUAD_11;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         quad_state <= QUAD_00;
      end else if (step_fwd) begin
         quad_state <= quad_ahead;
      end else if (step_rev) begin
         quad_state <= quad_behind;
      end
   end

   // Index pulse of fixed width; a new boundary restarts it
   logic [IDX_W-1:0] index_cnt;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         index_cnt <= '0;
      end else if (turn_done) begin
         index_cnt <= IDX_W'(INDEX_WIDTH_CYC);
      end else if (index_cnt != '0) begin
         index_cnt <= index_cnt - IDX_W'(1);
      end
   end

   // Low state bit rises first on a forward step
   logic lead_line;
   logic lag_line;
   logic line_a;
   logic line_b;
   logic index_level;

   assign lead_line   = quad_state[0];
   assign lag_line    = quad_state[1];

   // Phase order picks which output carries the leading line
   assign line_a      = phase_order_param ? lead_line : lag_line;
   assign line_b      = phase_order_param ? lag_line : lead_line;
   assign index_level = (index_cnt != '0);

   // Outputs straight from flip-flops; each pair holds true and inverse
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         enc_pins.quad_a_out         <= 1'b0;
         enc_pins.quad_a_out_n       <= 1'b1;
         enc_pins.quad_b_out         <= 1'b0;
         enc_pins.quad_b_out_n       <= 1'b1;
         enc_pins.index_single_ended <= 1'b0;
         enc_pins.index_out          <= 1'b0;
         enc_pins.index_out_n        <= 1'b1;
      end else begin
         enc_pins.quad_a_out         <= line_a;
         enc_pins.quad_a_out_n       <= ~line_a;
         enc_pins.quad_b_out         <= line_b;
         enc_pins.quad_b_out_n       <= ~line_b;
         enc_pins.index_single_ended <= index_level;
         enc_pins.index_out          <= index_level;
         enc_pins.index_out_n        <= ~index_level;
      end
   end
endmodule : pulse_command_encoder_emulation

// *** shared/pulse_enc_pkg.sv ***
// Constants and carriers for the pulse command and encoder emulation block.
// Assumes a single 200 MHz core clock and synchronous active-low reset.
package pulse_enc_pkg;
   localparam int          CLK_HZ              = 200_000_000;
   localparam int          OC_MAX_PPS          = 200_000;
   localparam int          DIFF_MAX_PPS        = 500_000;
   // Shortest pulse period at the differential maximum, in cycles
   localparam int          DIFF_MIN_PERIOD_CYC = CLK_HZ / DIFF_MAX_PPS;
   localparam int          POS_WIDTH           = 32;
   localparam int          PPT_WIDTH           = 16;
   localparam int          STEP_WIDTH          = 16;
   localparam logic [15:0] PPT_RESET           = 16'h0fa0;
   localparam int          INDEX_WIDTH_CYC     = 4;
   localparam int          SYNC_STAGES         = 2;

   typedef enum logic [1:0] {
      MODE_EXT_POS = 2'h0,
      MODE_INT_POS = 2'h1,
      MODE_SPEED   = 2'h3,
      MODE_TORQUE  = 2'h2
   } control_mode_type;

   typedef struct packed {
      logic fwd_pulse_pos;
      logic fwd_pulse_neg;
      logic rev_pulse_pos;
      logic rev_pulse_neg;
   } cmd_pins_type;

   typedef struct packed {
      logic quad_a_out;
      logic quad_a_out_n;
      logic quad_b_out;
      logic quad_b_out_n;
      logic index_out;
      logic index_out_n;
      logic index_single_ended;
   } enc_pins_type;
endpackage : pulse_enc_pkg

// *** test/pce_chk.sv ***
// Port checker for the pulse command and encoder emulation block.
// Bound to the design; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module pce_chk import pulse_enc_pkg::*; #(
   parameter int POS_W = 32,
   parameter int PPT_W = 16
) (
   input wire logic             core_clk,              // Clock
   input wire logic             nrst,                  // Reset
   input wire control_mode_type control_mode,          // Mode
   input wire cmd_pins_type     cmd_pins,              // Pulse pins
   input wire logic [PPT_W-1:0] pulses_per_turn_param, // Per turn
   input wire logic             phase_order_param,     // Order
   input wire logic             motor_step,            // Step
   input wire logic             motor_step_dir,        // Direction
   input wire enc_pins_type     enc_pins,              // Encoder pins
   input wire logic [POS_W-1:0] position_command       // Count
);
   wire  a = enc_pins.quad_a_out;
   wire  b = enc_pins.quad_b_out;
   wire  z = enc_pins.index_single_ended;
   logic key;
   // Leading-channel key of the latest step
   always_ff @(posedge core_clk) if (motor_step) key <= motor_step_dir ^ phase_order_param;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   sequence s_zpulse; z [*4] ##1 !z; endsequence
   property p_pair; enc_pins.quad_a_out_n != a && enc_pins.quad_b_out_n != b; endproperty
   property p_idx; enc_pins.index_out == z && enc_pins.index_out_n != z; endproperty
   property p_quad; $changed(a) |-> $stable(b); endproperty
   property p_fwd; $changed({a, b}) && key |-> a == $past(b) && b != $past(a); endproperty
   property p_rev; $changed({a, b}) && !key |-> a != $past(b) && b == $past(a); endproperty
   property p_z; $rose(z) |-> $past(motor_step, 2) ##0 s_zpulse; endproperty
   property p_inc;
      $changed(position_command) |->
         position_command == $past(position_command) + 1'b1 ||
         position_command + 1'b1 == $past(position_command);
   endproperty
   property p_mode; $changed(position_command) |-> $past(control_mode) == MODE_EXT_POS;
   endproperty
   a_pair: assert property (p_pair) else $error("pair not inverse");
   a_idx: assert property (p_idx) else $error("index copy wrong");
   a_quad: assert property (p_quad) else $error("a and b moved together");
   a_fwd: assert property (p_fwd) else $error("wrong lead");
   a_rev: assert property (p_rev) else $error("wrong lag");
   a_z: assert property (p_z) else $error("bad index pulse");
   a_inc: assert property (p_inc) else $error("count jump");
   a_mode: assert property (p_mode) else $error("count outside mode");
endmodule : pce_chk
bind pulse_command_encoder_emulation pce_chk #(.POS_W(POS_W), .PPT_W(PPT_W)) i_chk (
   .core_clk, .nrst, .control_mode, .cmd_pins, .pulses_per_turn_param,
   .phase_order_param, .motor_step, .motor_step_dir, .enc_pins, .position_command);

// *** test/pulse_ctl.sv ***
// External controller model issuing command pulses.
// Bench calls send; pins move just after core_clk edges.
`timescale 1ns/10ps
module pulse_ctl import pulse_enc_pkg::*; (
   input  wire logic    core_clk, // Drive clock
   output cmd_pins_type cmd_pins  // Pulse pins
);
   initial cmd_pins = 4'h5;
   // One pulse on one pair, at the top rate of its form
   task automatic send(input logic rev, input logic oc);
      int h;
      h = oc ? CLK_HZ / OC_MAX_PPS / 2 : DIFF_MIN_PERIOD_CYC / 2;
      @(posedge core_clk);
      cmd_pins <= oc ? (rev ? 4'h2 : 4'h8) : (rev ? 4'h6 : 4'h9);
      repeat (h) @(posedge core_clk);
      cmd_pins <= oc ? 4'h0 : 4'h5;
      repeat (h) @(posedge core_clk);
   endtask : send
endmodule : pulse_ctl

// *** test/tb.sv ***
// Self-checking bench for the pulse command and encoder emulation block.
// Controller model makes command pulses; the bench makes motor steps.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t mismatch", $time); end end
module tb;
   import pulse_enc_pkg::*;
   logic             core_clk = 0, nrst = 0, phase_order_param = 0;
   logic             motor_step = 0, motor_step_dir = 0;
   control_mode_type control_mode = MODE_EXT_POS;
   logic [15:0]      pulses_per_turn_param = 16'h0001;
   cmd_pins_type     cmd_pins;
   enc_pins_type     enc_pins;
   logic [31:0]      position_command;
   int               num_errors = 0, check_count = 0, n_a = 0, n_z = 0, exp_pos = 0;
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      n_a <= n_a + int'($rose(enc_pins.quad_a_out));
      n_z <= n_z + int'($rose(enc_pins.index_single_ended));
   end
   pulse_ctl i_ctl (.core_clk(core_clk), .cmd_pins(cmd_pins));
   pulse_command_encoder_emulation i_dut (.core_clk, .nrst, .control_mode, .cmd_pins,
      .pulses_per_turn_param, .phase_order_param, .motor_step, .motor_step_dir,
      .enc_pins, .position_command);
   function automatic int turn_steps(input int ppt); return 4 * ppt; endfunction : turn_steps
   task automatic step(input logic d, input int k);
      repeat (k) begin
         @(posedge core_clk);
         motor_step <= 1'b1;
         motor_step_dir <= d;
         @(posedge core_clk);
         motor_step <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
      repeat (2) @(posedge core_clk);
   endtask : step
   task automatic wrap_up;
      if (num_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   initial begin
      #200us;
      num_errors++;
      wrap_up();
   end
   initial begin
      int r, ppt, a0, z0;
      void'($urandom(32'h5957));
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      // First four cover both pairs in both forms
      for (int i = 0; i < 10; i++) begin
         r = (i < 4) ? i : $urandom;
         i_ctl.send(r[0], r[1]);
         exp_pos += r[0] ? -1 : 1;
      end
      repeat (4) @(posedge core_clk);
      `CHK(position_command, 32'(exp_pos))
      for (int m = 1; m < 4; m++) begin
         control_mode <= control_mode_type'(m[1:0]);
         i_ctl.send(m[0], 1'b0);
         repeat (4) @(posedge core_clk);
         `CHK(position_command, 32'(exp_pos))
      end
      for (int p = 0; p < 2; p++) begin
         ppt = $urandom_range(3, 1);
         phase_order_param <= p[0];
         pulses_per_turn_param <= 16'(ppt);
         @(posedge core_clk);
         a0 = n_a;
         z0 = n_z;
         step(1'b1, turn_steps(ppt));
         `CHK(n_a - a0, ppt)
         `CHK(n_z - z0, 1)
         step(1'b0, turn_steps(ppt));
         `CHK(n_a - a0, 2 * ppt)
         `CHK(n_z - z0, 2)
      end
      wrap_up();
   end
endmodule : tb
